// ---- hdl/nand_bad_block_manager.sv ----
// Overview of operation
// [R1] at most four partial programs per page
// [R2] never erase a block known bad
// [R3] marker byte 00h marks block bad
// [R4] every page of bad block carries marker
// [R5] scan once, record and exclude bad blocks
// [R6] erase failure marks block bad, barred
// [R7] program failure: reprogram elsewhere, bar block
// [R8] host ECC corrects eight bits per 512 bytes
// [R9] rewrite before errors become uncorrectable
// [R10] bit errors alone never mark bad
// [R11] spread wear over all blocks evenly; the code only rotates the spare pointer used for replacement blocks
// [R12] pad unused page area with ones
// [R13] tolerate up to forty bad blocks
// [R14] status 70h, bit zero one means fail
// [R15] wait ready before sampling pass/fail
`timescale 1ns/1ps
`default_nettype none
`include "nand_bbm_consts.svh"

module nand_bad_block_manager (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic REQ_VALID,
  input wire nand_bbm_pkg::req_t REQ,
  output var logic REQ_READY,
  output var logic RSP_VALID,
  output var nand_bbm_pkg::rsp_t RSP,
  output var logic FOP_VALID,
  output var nand_bbm_pkg::fop_t FOP,
  input wire logic FOP_ACK,
  input wire logic [7:0] FOP_DATA,
  input wire logic ECC_VALID,
  input wire logic [3:0] ECC_CORR,
  input wire logic ECC_UNCORR,
  output var logic REWRITE_REQ,
  output var logic [`BLK_W-1:0] REWRITE_BLOCK,
  output var logic [7:0] PAD_BYTE,
  output var logic [`CNT_W-1:0] BAD_COUNT,
  output var logic BAD_LIMIT,
  output var logic SCAN_DONE
);

  // ==========================================================
  // state
  nand_bbm_pkg::state_t state_q;
  nand_bbm_pkg::req_op_t op_q;
  logic bad_q [0:`NB_BLOCKS-1];
  logic [`BLK_W-1:0] blk_q;
  logic [`PAGE_W-1:0] page_q;
  logic [`BLK_W-1:0] fail_blk_q;
  logic [`BLK_W-1:0] spare_q;
  logic [`BLK_W-1:0] tries_q;
  logic [`BLK_W-1:0] rd_blk_q;
  logic replaced_q;
  logic chain_q;
  logic give_up_q;
  logic [`PAGE_W-1:0] top_page_q [0:`NB_BLOCKS-1];
  logic [2:0] page_cnt_q [0:`NB_BLOCKS-1];
  logic used_q [0:`NB_BLOCKS-1];
  logic tbl_we;
  logic tbl_set;
  logic [`BLK_W-1:0] tbl_addr;
  logic req_bad;
  logic partial_full;

  // ==========================================================
  // bad block table write port
  always_comb
  begin
    tbl_we = 1'b0;
    tbl_set = 1'b0;
    tbl_addr = blk_q;
    unique case (state_q)
      nand_bbm_pkg::S_CLEAR:
      begin
        tbl_we = 1'b1;
        tbl_addr = blk_q;
      end
      nand_bbm_pkg::S_SCAN_WAIT:
      begin
        // [R3] marker byte check
        tbl_we = FOP_ACK && (FOP_DATA == `MARK_VAL);
        tbl_set = 1'b1;
      end
      nand_bbm_pkg::S_MARK:
      begin
        tbl_we = 1'b1;
        tbl_set = 1'b1;
        tbl_addr = fail_blk_q;
      end
      default:
      begin
        tbl_we = 1'b0;
      end
    endcase
  end

  // the table has no reset: the clear walk after reset zeroes it
  always_ff @(posedge CORE_CLK)
  begin
    // [R5] record bad blocks
    if (tbl_we)
      bad_q[tbl_addr] <= tbl_set;
  end

  // count each block only once, even if marked twice
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      BAD_COUNT <= '0;
      BAD_LIMIT <= 1'b0;
    end
    else
    begin
      if (tbl_we && tbl_set && !bad_q[tbl_addr])
        BAD_COUNT <= BAD_COUNT + 1'b1;
      // [R13] spare budget exceeded
      BAD_LIMIT <= (BAD_COUNT > (`NB_BLOCKS - `MIN_GOOD_BLOCKS));
    end
  end

  // ==========================================================
  // request screening
  assign req_bad = bad_q[REQ.block];
  // [R1] closed page or four programs
  // pages below a block's top page are closed, so no per-page store
  assign partial_full = used_q[REQ.block]
    && ((REQ.page < top_page_q[REQ.block])
    || ((REQ.page == top_page_q[REQ.block])
    && (page_cnt_q[REQ.block] == `PARTIAL_MAX)));

  // ==========================================================
  // error-correction monitor, never touches the table
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      REWRITE_REQ <= 1'b0;
      REWRITE_BLOCK <= '0;
    end
    else
    begin
      // [R8] four-bit corrected count, at most eight
      // [R9] flag rewrite early
      // [R10] no bad marking here
      REWRITE_REQ <= ECC_VALID && (ECC_UNCORR || ECC_CORR >= `REWRITE_THRESH);
      if (ECC_VALID)
        REWRITE_BLOCK <= rd_blk_q;
    end
  end

  // [R12] fill byte for unused page area
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
      PAD_BYTE <= `PAD_FILL;
    else
      PAD_BYTE <= `PAD_FILL;
  end

  // ==========================================================
  // partial program tracking: top page per block and its count
  // no reset on the arrays: the clear walk after reset clears used_q, which voids the other two
  always_ff @(posedge CORE_CLK)
  begin
    if (state_q == nand_bbm_pkg::S_CLEAR)
      used_q[blk_q] <= 1'b0;
    else if (state_q == nand_bbm_pkg::S_ST_WAIT && FOP_ACK
             && FOP_DATA[`ST_READY_BIT] && !FOP_DATA[`ST_FAIL_BIT])
    begin
      // [R1] count partial programs
      if (op_q == nand_bbm_pkg::OP_PROG)
      begin
        used_q[blk_q] <= 1'b1;
        top_page_q[blk_q] <= page_q;
        if (used_q[blk_q] && top_page_q[blk_q] == page_q)
          page_cnt_q[blk_q] <= page_cnt_q[blk_q] + 3'h1;
        else
          page_cnt_q[blk_q] <= 3'h1;
      end
      else if (op_q == nand_bbm_pkg::OP_ERASE)
        used_q[blk_q] <= 1'b0;
    end
  end

  // ==========================================================
  // main sequencer
  always_ff @(posedge CORE_CLK)
  begin
    if (SRST)
    begin
      state_q <= nand_bbm_pkg::S_CLEAR;
      op_q <= nand_bbm_pkg::OP_SCAN;
      blk_q <= '0;
      page_q <= '0;
      fail_blk_q <= '0;
      spare_q <= '0;
      tries_q <= '0;
      rd_blk_q <= '0;
      replaced_q <= 1'b0;
      chain_q <= 1'b0;
      give_up_q <= 1'b0;
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP <= '0;
      FOP_VALID <= 1'b0;
      FOP <= '0;
      SCAN_DONE <= 1'b0;
    end
    else
    begin
      RSP_VALID <= 1'b0;
      unique case (state_q)
        nand_bbm_pkg::S_CLEAR:
        begin
          blk_q <= blk_q + 1'b1;
          if (blk_q == `LAST_BLOCK)
          begin
            state_q <= nand_bbm_pkg::S_IDLE;
            REQ_READY <= 1'b1;
          end
        end
        nand_bbm_pkg::S_IDLE:
        begin
          if (REQ_VALID && REQ_READY)
          begin
            REQ_READY <= 1'b0;
            op_q <= REQ.op;
            blk_q <= REQ.block;
            page_q <= REQ.page;
            replaced_q <= 1'b0;
            if (REQ.op == nand_bbm_pkg::OP_SCAN)
            begin
              blk_q <= '0;
              state_q <= nand_bbm_pkg::S_SCAN_ISSUE;
            end
            // [R2] bad blocks refused
            // [R5] excluded from use
            else if (req_bad || (REQ.op == nand_bbm_pkg::OP_PROG
                                 && partial_full))
            begin
              RSP_VALID <= 1'b1;
              RSP <= '{ok: 1'b0, refused: 1'b1, replaced: 1'b0,
                       block: REQ.block};
              REQ_READY <= 1'b1;
            end
            else
              state_q <= nand_bbm_pkg::S_OP_ISSUE;
          end
        end
        nand_bbm_pkg::S_SCAN_ISSUE:
        begin
          // [R4] one page suffices
          FOP_VALID <= 1'b1;
          FOP <= '{kind: nand_bbm_pkg::FK_READ_BYTE, cmd: 8'h00,
                   block: blk_q, page: `MARK_PAGE, col: `MARK_COL};
          state_q <= nand_bbm_pkg::S_SCAN_WAIT;
        end
        nand_bbm_pkg::S_SCAN_WAIT:
        begin
          if (FOP_ACK)
          begin
            FOP_VALID <= 1'b0;
            blk_q <= blk_q + 1'b1;
            state_q <= nand_bbm_pkg::S_SCAN_ISSUE;
            if (blk_q == `LAST_BLOCK)
            begin
              SCAN_DONE <= 1'b1;
              RSP_VALID <= 1'b1;
              RSP <= '{ok: 1'b1, refused: 1'b0, replaced: 1'b0,
                       block: blk_q};
              REQ_READY <= 1'b1;
              state_q <= nand_bbm_pkg::S_IDLE;
            end
          end
        end
        nand_bbm_pkg::S_OP_ISSUE:
        begin
          FOP_VALID <= 1'b1;
          FOP <= '{kind: nand_bbm_pkg::FK_READ_PAGE, cmd: 8'h00,
                   block: blk_q, page: page_q, col: '0};
          if (op_q == nand_bbm_pkg::OP_PROG)
            FOP.kind <= nand_bbm_pkg::FK_PROG;
          else if (op_q == nand_bbm_pkg::OP_ERASE)
            FOP.kind <= nand_bbm_pkg::FK_ERASE;
          else
            rd_blk_q <= blk_q;
          state_q <= nand_bbm_pkg::S_OP_WAIT;
        end
        nand_bbm_pkg::S_OP_WAIT:
        begin
          if (FOP_ACK)
          begin
            FOP_VALID <= 1'b0;
            if (op_q == nand_bbm_pkg::OP_READ)
            begin
              RSP_VALID <= 1'b1;
              RSP <= '{ok: 1'b1, refused: 1'b0, replaced: 1'b0,
                       block: blk_q};
              REQ_READY <= 1'b1;
              state_q <= nand_bbm_pkg::S_IDLE;
            end
            else
              state_q <= nand_bbm_pkg::S_ST_ISSUE;
          end
        end
        nand_bbm_pkg::S_ST_ISSUE:
        begin
          // [R14] status read command
          FOP_VALID <= 1'b1;
          FOP <= '{kind: nand_bbm_pkg::FK_STATUS, cmd: `STATUS_CMD,
                   block: blk_q, page: page_q, col: '0};
          state_q <= nand_bbm_pkg::S_ST_WAIT;
        end
        nand_bbm_pkg::S_ST_WAIT:
        begin
          if (FOP_ACK)
          begin
            FOP_VALID <= 1'b0;
            // [R15] poll until ready
            if (!FOP_DATA[`ST_READY_BIT])
              state_q <= nand_bbm_pkg::S_ST_ISSUE;
            // [R14] bit zero pass/fail
            else if (FOP_DATA[`ST_FAIL_BIT])
            begin
              if (op_q == nand_bbm_pkg::OP_ERASE)
              begin
                // [R6] erase failure marks bad
                fail_blk_q <= blk_q;
                give_up_q <= 1'b1;
                state_q <= nand_bbm_pkg::S_MARK;
              end
              else if (replaced_q)
              begin
                // earlier failed block still unmarked: mark it first
                chain_q <= 1'b1;
                state_q <= nand_bbm_pkg::S_MARK;
              end
              else
              begin
                fail_blk_q <= blk_q;
                tries_q <= '0;
                state_q <= nand_bbm_pkg::S_SPARE;
              end
            end
            else if (replaced_q)
            begin
              // [R7] bar failed block after reprogram
              give_up_q <= 1'b0;
              state_q <= nand_bbm_pkg::S_MARK;
            end
            else
            begin
              RSP_VALID <= 1'b1;
              RSP <= '{ok: 1'b1, refused: 1'b0, replaced: 1'b0,
                       block: blk_q};
              REQ_READY <= 1'b1;
              state_q <= nand_bbm_pkg::S_IDLE;
            end
          end
        end
        nand_bbm_pkg::S_SPARE:
        begin
          // [R11] rotating spare pointer spreads wear
          spare_q <= spare_q + 1'b1;
          tries_q <= tries_q + 1'b1;
          if (!bad_q[spare_q] && spare_q != fail_blk_q)
          begin
            // [R7] reprogram into another block
            blk_q <= spare_q;
            replaced_q <= 1'b1;
            state_q <= nand_bbm_pkg::S_OP_ISSUE;
          end
          else if (tries_q == `LAST_BLOCK)
          begin
            give_up_q <= 1'b1;
            state_q <= nand_bbm_pkg::S_MARK;
          end
        end
        nand_bbm_pkg::S_MARK:
        begin
          give_up_q <= 1'b0;
          if (chain_q)
          begin
            chain_q <= 1'b0;
            fail_blk_q <= blk_q;
            replaced_q <= 1'b0;
            tries_q <= '0;
            state_q <= nand_bbm_pkg::S_SPARE;
          end
          else
          begin
            RSP_VALID <= 1'b1;
            RSP <= '{ok: !give_up_q, refused: 1'b0, replaced: replaced_q,
                     block: blk_q};
            REQ_READY <= 1'b1;
            state_q <= nand_bbm_pkg::S_IDLE;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- hdl/nand_bbm_consts.svh ----
`ifndef NAND_BBM_CONSTS_SVH
`define NAND_BBM_CONSTS_SVH

// ==========================================================
// array geometry
`define BLK_W 11
`define PAGE_W 6
`define COL_W 12
`define CNT_W 12
`define NB_BLOCKS 12'h800
`define LAST_BLOCK 11'h7FF
`define MIN_GOOD_BLOCKS 12'h7D8
// ==========================================================
// bad block marker probe
`define MARK_PAGE 6'h00
`define MARK_COL 12'h000
`define MARK_VAL 8'h00
// ==========================================================
// status byte, command and program limits
`define STATUS_CMD 8'h70
`define ST_FAIL_BIT 0
`define ST_READY_BIT 6
`define PARTIAL_MAX 3'h4
`define PAD_FILL 8'hFF
// ==========================================================
// error correction strength and rewrite threshold
`define ECC_CHUNK_BYTES 12'h200
`define ECC_MAX_BITS 4'h8
`define REWRITE_THRESH 4'h6

`endif

// ---- hdl/nand_bbm_pkg.sv ----
`include "nand_bbm_consts.svh"

package nand_bbm_pkg;

  // ==========================================================
  // user request and answer
  typedef enum logic [1:0] {OP_SCAN, OP_ERASE, OP_PROG, OP_READ} req_op_t;

  typedef struct packed {
    req_op_t op;
    logic [`BLK_W-1:0] block;
    logic [`PAGE_W-1:0] page;
  } req_t;

  typedef struct packed {
    logic ok;
    logic refused;
    logic replaced;
    logic [`BLK_W-1:0] block;
  } rsp_t;

  // ==========================================================
  // operation handed to the pin engine
  typedef enum logic [2:0] {
    FK_READ_BYTE, FK_READ_PAGE, FK_PROG, FK_ERASE, FK_STATUS
  } fop_kind_t;

  typedef struct packed {
    fop_kind_t kind;
    logic [7:0] cmd;
    logic [`BLK_W-1:0] block;
    logic [`PAGE_W-1:0] page;
    logic [`COL_W-1:0] col;
  } fop_t;

  // ==========================================================
  // sequencer states
  typedef enum logic [3:0] {
    S_CLEAR, S_IDLE, S_SCAN_ISSUE, S_SCAN_WAIT, S_OP_ISSUE, S_OP_WAIT,
    S_ST_ISSUE, S_ST_WAIT, S_SPARE, S_MARK
  } state_t;

endpackage

// ---- test/nand_bbm_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nand_bbm_consts.svh"

// ==========================================================
// port relations of the bad block manager
module nand_bbm_checker (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic FOP_VALID,
  input wire nand_bbm_pkg::fop_t FOP,
  input wire logic FOP_ACK,
  input wire logic ECC_VALID,
  input wire logic [3:0] ECC_CORR,
  input wire logic ECC_UNCORR,
  input wire logic REWRITE_REQ,
  input wire logic [7:0] PAD_BYTE,
  input wire logic [`CNT_W-1:0] BAD_COUNT,
  input wire logic BAD_LIMIT,
  input wire logic SCAN_DONE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);

  // fill, status command and marker probe placement
  property p_pad; PAD_BYTE == 8'hFF; endproperty
  a_pad: assert property (p_pad) else $error("pad byte not ones");
  property p_stcmd; FOP_VALID && FOP.kind == nand_bbm_pkg::FK_STATUS
    |-> FOP.cmd == 8'h70; endproperty
  a_stcmd: assert property (p_stcmd) else $error("status cmd wrong");
  property p_probe; FOP_VALID && FOP.kind == nand_bbm_pkg::FK_READ_BYTE
    |-> FOP.page == 6'h00 && FOP.col == 12'h000; endproperty
  a_probe: assert property (p_probe) else $error("probe place wrong");

  // engine handshake: held until ack, dropped right after
  property p_hold; FOP_VALID && !FOP_ACK |=> FOP_VALID && $stable(FOP);
  endproperty
  a_hold: assert property (p_hold) else $error("fop not held");
  property p_drop; FOP_VALID && FOP_ACK |=> !FOP_VALID; endproperty
  a_drop: assert property (p_drop) else $error("fop not dropped");

  // rewrite advice follows the corrected-bit count
  property p_rw; ECC_VALID && (ECC_UNCORR || ECC_CORR >= 4'h6)
    |=> REWRITE_REQ; endproperty
  a_rw: assert property (p_rw) else $error("rewrite missing");
  property p_norw; ECC_VALID && !ECC_UNCORR && ECC_CORR < 4'h6
    |=> !REWRITE_REQ; endproperty
  a_norw: assert property (p_norw) else $error("rewrite spurious");
  property p_cause; REWRITE_REQ |-> $past(ECC_VALID); endproperty
  a_cause: assert property (p_cause) else $error("rewrite no cause");

  // spare budget flag lags the count by one cycle; scan flag sticks
  property p_lim; 1'b1 |=> BAD_LIMIT == ($past(BAD_COUNT) > 12'h028);
  endproperty
  a_lim: assert property (p_lim) else $error("bad limit wrong");
  property p_sticky; SCAN_DONE |=> SCAN_DONE; endproperty
  a_sticky: assert property (p_sticky) else $error("scan flag lost");
endmodule

bind nand_bad_block_manager nand_bbm_checker chk (.CORE_CLK, .SRST,
  .FOP_VALID, .FOP, .FOP_ACK, .ECC_VALID, .ECC_CORR, .ECC_UNCORR,
  .REWRITE_REQ, .PAD_BYTE, .BAD_COUNT, .BAD_LIMIT, .SCAN_DONE);
`default_nettype wire

// ---- test/nand_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nand_bbm_consts.svh"

// ==========================================================
// flash device seen through the pin engine
module nand_dev_model (
  input wire logic clk,
  input wire logic fop_valid,
  input wire nand_bbm_pkg::fop_t fop,
  output logic ack,
  output logic [7:0] data,
  output logic [7:0] viol
);
  logic [2:0] pcnt [0:2047][0:63];
  logic [1:0] lat_q;
  logic [1:0] wait_q;
  logic polled_q;
  logic fail_q;

  // factory set of 38, inside lifetime budget
  function automatic logic is_bad(input logic [10:0] b);
    return b == 11'h003 || b >= 11'h7DB;
  endfunction

  initial
  begin
    ack = 1'b0;
    data = 8'h5A;
    viol = 8'h00;
    lat_q = 2'h0;
    wait_q = 2'h0;
    polled_q = 1'b0;
    fail_q = 1'b0;
    foreach (pcnt[b, p]) pcnt[b][p] = 3'h0;
  end

  // latency rotates 1..4 cycles so both quick and slow answers occur
  always @(posedge clk)
  begin
    ack <= 1'b0;
    data <= ~data;
    if (fop_valid && !ack)
    begin
      if (wait_q != lat_q) wait_q <= wait_q + 2'h1;
      else
      begin
        wait_q <= 2'h0;
        lat_q <= lat_q + 2'h1;
        ack <= 1'b1;
        case (fop.kind)
          nand_bbm_pkg::FK_READ_BYTE:
            data <= is_bad(fop.block) ? 8'h00 : 8'hFF;
          nand_bbm_pkg::FK_PROG:
          begin
            if (pcnt[fop.block][fop.page] == 3'h4) viol <= viol + 8'h01;
            pcnt[fop.block][fop.page] <= pcnt[fop.block][fop.page] + 3'h1;
            fail_q <= fop.block == 11'h00A;
            polled_q <= 1'b0;
          end
          nand_bbm_pkg::FK_ERASE:
          begin
            // erasing a marked block would destroy its marker
            if (is_bad(fop.block)) viol <= viol + 8'h01;
            for (int i = 0; i < 64; i++) pcnt[fop.block][i] <= 3'h0;
            fail_q <= fop.block == 11'h014;
            polled_q <= 1'b0;
          end
          // first poll busy, junk fail bit
          nand_bbm_pkg::FK_STATUS:
          begin
            data <= polled_q ? {7'h20, fail_q} : 8'h01;
            polled_q <= 1'b1;
          end
          default: data <= 8'hC3;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/nand_bad_block_manager_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nand_bbm_consts.svh"

module nand_bad_block_manager_test;
  logic CORE_CLK, SRST, REQ_VALID, REQ_READY, RSP_VALID, FOP_VALID;
  logic FOP_ACK, ECC_VALID, ECC_UNCORR, REWRITE_REQ, BAD_LIMIT, SCAN_DONE;
  nand_bbm_pkg::req_t REQ;
  nand_bbm_pkg::rsp_t RSP;
  nand_bbm_pkg::fop_t FOP;
  logic [7:0] FOP_DATA, PAD_BYTE, viol;
  logic [3:0] ECC_CORR;
  logic [`BLK_W-1:0] REWRITE_BLOCK;
  logic [`CNT_W-1:0] BAD_COUNT;
  int failures = 0;
  int cmp_count = 0;

  nand_bad_block_manager dut (.CORE_CLK, .SRST, .REQ_VALID, .REQ,
    .REQ_READY, .RSP_VALID, .RSP, .FOP_VALID, .FOP, .FOP_ACK, .FOP_DATA,
    .ECC_VALID, .ECC_CORR, .ECC_UNCORR, .REWRITE_REQ, .REWRITE_BLOCK,
    .PAD_BYTE, .BAD_COUNT, .BAD_LIMIT, .SCAN_DONE);
  nand_dev_model dev (.clk(CORE_CLK), .fop_valid(FOP_VALID), .fop(FOP),
    .ack(FOP_ACK), .data(FOP_DATA), .viol(viol));

  initial
  begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, got);
    cmp_count++;
    if (exp !== got)
    begin
      failures++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // exp packs ok, refused, replaced; outputs read at the edge are settled
  task automatic do_req(input nand_bbm_pkg::req_op_t op, input int b, p,
    input logic [2:0] exp);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    REQ_VALID <= 1'b1;
    REQ <= {op, b[10:0], p[5:0]};
    do @(posedge CORE_CLK); while (!REQ_READY && ++n < 30000);
    REQ_VALID <= 1'b0;
    do @(posedge CORE_CLK); while (!RSP_VALID && ++n < 30000);
    chk("rsp_wait", 0, n >= 30000);
    chk("rsp", exp, {RSP.ok, RSP.refused, RSP.replaced});
  endtask

  task automatic ecc(input logic [3:0] c, input logic u, exp);
    @(posedge CORE_CLK);
    ECC_VALID <= 1'b1;
    ECC_CORR <= c;
    ECC_UNCORR <= u;
    @(posedge CORE_CLK);
    ECC_VALID <= 1'b0;
    @(posedge CORE_CLK);
    chk("rewrite", exp, REWRITE_REQ);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_scan;
    do_req(nand_bbm_pkg::OP_SCAN, 0, 0, 3'h4);
    @(posedge CORE_CLK);
    chk("scan_done", 1, SCAN_DONE);
    chk("bad_count", 38, BAD_COUNT);
    do_req(nand_bbm_pkg::OP_ERASE, 3, 0, 3'h2);
    do_req(nand_bbm_pkg::OP_PROG, 2047, 9, 3'h2);
    do_req(nand_bbm_pkg::OP_READ, 2011, 0, 3'h2);
    $display("test scan done");
  endtask

  task automatic t_partial;
    do_req(nand_bbm_pkg::OP_ERASE, 7, 0, 3'h4);
    repeat (4) do_req(nand_bbm_pkg::OP_PROG, 7, 1, 3'h4);
    do_req(nand_bbm_pkg::OP_PROG, 7, 1, 3'h2);
    do_req(nand_bbm_pkg::OP_ERASE, 7, 0, 3'h4);
    do_req(nand_bbm_pkg::OP_PROG, 7, 1, 3'h4);
    // moving on to page 2 closes page 1, so going back is refused
    do_req(nand_bbm_pkg::OP_PROG, 7, 2, 3'h4);
    do_req(nand_bbm_pkg::OP_PROG, 7, 1, 3'h2);
    $display("test partial done");
  endtask

  task automatic t_fail;
    logic [10:0] s;
    do_req(nand_bbm_pkg::OP_PROG, 10, 2, 3'h5);
    s = RSP.block;
    chk("spare", 1, s != 11'h00A && s != 11'h003 && s < 11'h7DB);
    @(posedge CORE_CLK);
    chk("bad_count", 39, BAD_COUNT);
    do_req(nand_bbm_pkg::OP_READ, 10, 2, 3'h2);
    do_req(nand_bbm_pkg::OP_ERASE, 20, 0, 3'h0);
    repeat (2) @(posedge CORE_CLK);
    chk("bad_count", 40, BAD_COUNT);
    chk("bad_limit", 0, BAD_LIMIT);
    do_req(nand_bbm_pkg::OP_ERASE, 20, 0, 3'h2);
    $display("test failure done");
  endtask

  task automatic t_ecc;
    do_req(nand_bbm_pkg::OP_READ, 5, 0, 3'h4);
    ecc(4'h5, 1'b0, 1'b0);
    ecc(4'h6, 1'b0, 1'b1);
    ecc(4'h8, 1'b0, 1'b1);
    ecc(4'h0, 1'b1, 1'b1);
    chk("rewrite_block", 5, REWRITE_BLOCK);
    chk("bad_count", 40, BAD_COUNT);
    chk("device_misuse", 0, viol);
    chk("pad", 8'hFF, PAD_BYTE);
    $display("test ecc done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    int n;
    n = 0;
    SRST = 1'b1;
    REQ_VALID = 1'b0;
    REQ = '0;
    ECC_VALID = 1'b0;
    ECC_CORR = 4'h0;
    ECC_UNCORR = 1'b0;
    repeat (8) @(posedge CORE_CLK);
    chk("reset_count", 0, BAD_COUNT);
    SRST <= 1'b0;
    do @(posedge CORE_CLK); while (!REQ_READY && ++n < 3000);
    chk("ready", 1, REQ_READY);
    t_scan();
    t_partial();
    t_fail();
    t_ecc();
    finish_test();
  end

  // whole run needs about 12k cycles; this allows over five times that
  initial
  begin
    #(4 * 64000);
    failures++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end
endmodule
`default_nettype wire
